// [rtc_aux_regs.vh]
`ifndef RTC_AUX_REGS_VH
`define RTC_AUX_REGS_VH
// Register addresses of the serial register port.
`define ADDR_TRIM_INIT      8'h0B
`define ADDR_TRIM_SCALE     8'h0C
`define ADDR_FINAL_ANALOG   8'h0E
`define ADDR_FINAL_DIGITAL  8'h0F
`define ADDR_STATUS         8'h07
`define ADDR_PWR_CTRL       8'h09
`define ADDR_FWD_MONTH      8'h20
`define ADDR_FWD_DAY_WEEK   8'h21
`define ADDR_FWD_DATE       8'h22
`define ADDR_FWD_HOUR       8'h23
`define ADDR_REV_MONTH      8'h24
`define ADDR_REV_DAY_WEEK   8'h25
`define ADDR_REV_DATE       8'h26
`define ADDR_REV_HOUR       8'h27
`define ADDR_TEMP_LOW       8'h28
`define ADDR_TEMP_HIGH      8'h29
`define ADDR_NET_CORR_LOW   8'h2A
`define ADDR_NET_CORR_HIGH  8'h2B
`define ADDR_TURNOVER       8'h2C
`define ADDR_HOT_COEFF      8'h2D
`define ADDR_COLD_COEFF     8'h2E
`define ADDR_STAMP_MB_BASE  8'h30
`define ADDR_STAMP_BM_BASE  8'h38
`define STAMP_BYTES         5
// Field positions.
`define BIT_DST_ENABLE      7
`define BIT_WD_PRIORITY     6
`define BIT_STAMP_CLEAR     7
`define BIT_TEMP_SENSE_EN   7
`define BIT_DST_APPLIED     5
// Reset values.
`define RST_ZERO            8'h00
`define RST_REV_MONTH       8'h10
`define RST_TURNOVER        5'h00
`define RST_COEFF           7'h00
// Arithmetic constants.
`define TEMP_REF_BASE       10'h254
`define WEEK_LAST           3'h7
`define CORR_SHIFT          12
`define DIGITAL_TRIM_BIAS   8'h10
`endif

// [dst_match.v]
`timescale 1ns/1ps
`default_nettype none
`include "rtc_aux_regs.vh"
module dst_match (
  input  wire [7:0] i_month_reg,
  input  wire [7:0] i_day_week_reg,
  input  wire [7:0] i_date_reg,
  input  wire [7:0] i_hour_reg,
  input  wire [4:0] i_rtc_month,
  input  wire [5:0] i_rtc_date,
  input  wire [2:0] i_rtc_weekday,
  input  wire [5:0] i_rtc_hour,
  input  wire [2:0] i_rtc_week_of_month,
  input  wire       i_rtc_last_week,
  output wire       o_match
);
  wire       weekday_priority;
  wire [2:0] sched_week;
  wire       week_ok;
  wire       day_ok;
  // Week/weekday or date decides the day; month and hour always must agree.
  assign weekday_priority = i_day_week_reg[`BIT_WD_PRIORITY];
  assign sched_week       = i_day_week_reg[5:3];
  assign week_ok = (sched_week == `WEEK_LAST) ? i_rtc_last_week
                                              : (sched_week == i_rtc_week_of_month);
  assign day_ok  = weekday_priority ? (week_ok && (i_day_week_reg[2:0] == i_rtc_weekday))
                                    : (i_date_reg[5:0] == i_rtc_date);
  // Hour compare ignores the mode bit; the stored hour uses the clock's own format.
  assign o_match = (i_month_reg[4:0] == i_rtc_month) && day_ok &&
                   (i_hour_reg[5:0] == i_rtc_hour);
endmodule
`default_nettype wire

// [temp_comp.v]
`timescale 1ns/1ps
`default_nettype none
`include "rtc_aux_regs.vh"
module temp_comp (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_sample_valid,
  input  wire [9:0]  i_sample,
  input  wire        i_sense_en,
  input  wire [4:0]  i_turnover,
  input  wire [6:0]  i_hot_coeff,
  input  wire [6:0]  i_cold_coeff,
  input  wire [7:0]  i_init_offset,
  output reg  [9:0]  o_temp_code,
  output reg  [15:0] o_net_corr
);
  reg        have_first_reg;
  reg  [9:0] first_reg;
  wire [10:0] sum;
  wire [9:0]  ref_code;
  wire [10:0] dev;
  wire [6:0]  coeff;
  wire [27:0] curv;
  // Turnover field is sign-magnitude in half degrees around the base code.
  assign ref_code = i_turnover[4] ? (`TEMP_REF_BASE - {6'h00, i_turnover[3:0]})
                                  : (`TEMP_REF_BASE + {6'h00, i_turnover[3:0]});
  assign sum   = {1'b0, first_reg} + {1'b0, i_sample};
  assign dev   = (o_temp_code >= ref_code) ? {1'b0, o_temp_code - ref_code}
                                           : {1'b0, ref_code - o_temp_code};
  assign coeff = (o_temp_code >= ref_code) ? i_hot_coeff : i_cold_coeff;
  assign curv  = {21'h000000, coeff} * {17'h00000, dev} * {17'h00000, dev};
  // Two successive conversions are averaged into one reported code.
  always @(posedge i_clk) begin
    if (i_rst) begin
      have_first_reg <= 1'b0;
      first_reg      <= 10'h000;
      o_temp_code    <= 10'h000;
      o_net_corr     <= 16'h0000;
    end else begin
      if (i_sense_en && i_sample_valid) begin
        have_first_reg <= ~have_first_reg;
        first_reg      <= i_sample;
        if (have_first_reg) begin
          o_temp_code <= sum[10:1];
        end
      end
      o_net_corr <= {{8{i_init_offset[7]}}, i_init_offset} +
                    curv[27:`CORR_SHIFT];
    end
  end
endmodule
`default_nettype wire

// [rtc_aux.v]
`timescale 1ns/1ps
`default_nettype none
`include "rtc_aux_regs.vh"
module rtc_aux (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  input  wire [7:0]  i_rtc_seconds,
  input  wire [7:0]  i_rtc_minutes,
  input  wire [7:0]  i_rtc_hours,
  input  wire [7:0]  i_rtc_date,
  input  wire [7:0]  i_rtc_month,
  input  wire [2:0]  i_rtc_weekday,
  input  wire [2:0]  i_rtc_week_of_month,
  input  wire        i_rtc_last_week,
  input  wire        i_hour_tick,
  input  wire        i_on_battery,
  input  wire        i_temp_valid,
  input  wire [9:0]  i_temp_sample,
  output reg         o_hour_advance,
  output reg         o_hour_retard,
  output wire        o_summer_time_applied_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  reg  [7:0] fwd_month_reg;
  reg  [7:0] fwd_day_week_reg;
  reg  [7:0] fwd_date_reg;
  reg  [7:0] fwd_hour_reg;
  reg  [7:0] rev_month_reg;
  reg  [7:0] rev_day_week_reg;
  reg  [7:0] rev_date_reg;
  reg  [7:0] rev_hour_reg;
  reg        applied_reg;
  reg        temp_sense_enable_reg;
  reg  [4:0] turnover_reg;
  reg  [6:0] hot_coeff_reg;
  reg  [6:0] cold_coeff_reg;
  reg  [7:0] trim_init_reg;
  reg  [7:0] trim_scale_reg;
  reg  [7:0] final_analog_reg;
  reg  [7:0] final_digital_reg;
  // Five stamp bytes per set: seconds, minutes, hours, date, month.
  reg  [7:0] stamp_mb_reg [0:4];
  reg  [7:0] stamp_bm_reg [0:4];
  reg        mb_taken_reg;
  reg        on_batt_reg;
  reg        fwd_armed_reg;
  reg        rev_armed_reg;
  reg        fwd_hit_reg;
  reg        rev_hit_reg;
  wire       enable;
  wire       fwd_match;
  wire       rev_match;
  wire       wr_stamp_clear;
  wire       to_batt;
  wire       to_main;
  wire       dst_off_wr;
  wire       fwd_fire;
  wire       rev_fire;
  wire [9:0] temp_code;
  wire [15:0] net_corr;
  wire [39:0] now_bytes;
  integer    k;

  assign enable = fwd_month_reg[`BIT_DST_ENABLE];
  assign o_summer_time_applied_flag = applied_reg;
  assign wr_stamp_clear = i_reg_wr && (i_reg_addr == `ADDR_PWR_CTRL) &&
                          i_reg_wdata[`BIT_STAMP_CLEAR];
  assign to_batt = i_on_battery && !on_batt_reg;
  assign to_main = !i_on_battery && on_batt_reg;
  // Stamp bytes in clock order: seconds, minutes, hours, date, month.
  assign now_bytes = {i_rtc_month, i_rtc_date, i_rtc_hours, i_rtc_minutes,
                      i_rtc_seconds};

  ////////////////////////////////////////////////////////////////////////////
  // Summer time event qualifiers.
  // Writing the enable low clears the applied flag at the write itself, so the
  // very next read of the status register already shows it clear.
  assign dst_off_wr = i_reg_wr && (i_reg_addr == `ADDR_FWD_MONTH) &&
                      !i_reg_wdata[`BIT_DST_ENABLE];
  // A schedule fires on the first cycle of its match, only when it was armed at
  // the previous hour boundary. The flag makes forward and reverse alternate,
  // so the hour that repeats after a set-back cannot fire the reverse again.
  assign fwd_fire = enable && fwd_match && !fwd_hit_reg && fwd_armed_reg &&
                    !applied_reg;
  assign rev_fire = enable && rev_match && !rev_hit_reg && rev_armed_reg &&
                    applied_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Schedule comparators.
  // Both comparators see the same clock bytes; mode bits of the hour and the
  // unused upper bits of date and month never take part in a match.
  dst_match u_fwd (
    .i_month_reg         (fwd_month_reg),
    .i_day_week_reg      (fwd_day_week_reg),
    .i_date_reg          (fwd_date_reg),
    .i_hour_reg          (fwd_hour_reg),
    .i_rtc_month         (i_rtc_month[4:0]),
    .i_rtc_date          (i_rtc_date[5:0]),
    .i_rtc_weekday       (i_rtc_weekday),
    .i_rtc_hour          (i_rtc_hours[5:0]),
    .i_rtc_week_of_month (i_rtc_week_of_month),
    .i_rtc_last_week     (i_rtc_last_week),
    .o_match             (fwd_match)
  );
  dst_match u_rev (
    .i_month_reg         (rev_month_reg),
    .i_day_week_reg      (rev_day_week_reg),
    .i_date_reg          (rev_date_reg),
    .i_hour_reg          (rev_hour_reg),
    .i_rtc_month         (i_rtc_month[4:0]),
    .i_rtc_date          (i_rtc_date[5:0]),
    .i_rtc_weekday       (i_rtc_weekday),
    .i_rtc_hour          (i_rtc_hours[5:0]),
    .i_rtc_week_of_month (i_rtc_week_of_month),
    .i_rtc_last_week     (i_rtc_last_week),
    .o_match             (rev_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Temperature averaging and compensation arithmetic.
  // Conversions only count while sensing is enabled, so a stale sample taken
  // with sensing off can never be paired with a fresh one.
  temp_comp u_comp (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_sample_valid (i_temp_valid),
    .i_sample       (i_temp_sample),
    .i_sense_en     (temp_sense_enable_reg),
    .i_turnover     (turnover_reg),
    .i_hot_coeff    (hot_coeff_reg),
    .i_cold_coeff   (cold_coeff_reg),
    .i_init_offset  (trim_init_reg),
    .o_temp_code    (temp_code),
    .o_net_corr     (net_corr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register writes.
  // Reserved bits are masked on write so that they always read back as zero.
  always @(posedge i_clk) begin
    if (i_rst) begin
      fwd_month_reg         <= `RST_ZERO;
      fwd_day_week_reg      <= `RST_ZERO;
      fwd_date_reg          <= `RST_ZERO;
      fwd_hour_reg          <= `RST_ZERO;
      rev_month_reg         <= `RST_REV_MONTH;
      rev_day_week_reg      <= `RST_ZERO;
      rev_date_reg          <= `RST_ZERO;
      rev_hour_reg          <= `RST_ZERO;
      temp_sense_enable_reg <= 1'b0;
      turnover_reg          <= `RST_TURNOVER;
      hot_coeff_reg         <= `RST_COEFF;
      cold_coeff_reg        <= `RST_COEFF;
      trim_init_reg         <= `RST_ZERO;
      trim_scale_reg        <= `RST_ZERO;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `ADDR_FWD_MONTH:    fwd_month_reg    <= i_reg_wdata & 8'h9F;
        `ADDR_FWD_DAY_WEEK: fwd_day_week_reg <= i_reg_wdata & 8'h7F;
        `ADDR_FWD_DATE:     fwd_date_reg     <= i_reg_wdata & 8'h3F;
        `ADDR_FWD_HOUR:     fwd_hour_reg     <= i_reg_wdata & 8'h3F;
        `ADDR_REV_MONTH:    rev_month_reg    <= i_reg_wdata & 8'h1F;
        `ADDR_REV_DAY_WEEK: rev_day_week_reg <= i_reg_wdata & 8'h7F;
        `ADDR_REV_DATE:     rev_date_reg     <= i_reg_wdata & 8'h3F;
        `ADDR_REV_HOUR:     rev_hour_reg     <= i_reg_wdata & 8'h3F;
        `ADDR_PWR_CTRL:     temp_sense_enable_reg <= i_reg_wdata[`BIT_TEMP_SENSE_EN];
        `ADDR_TURNOVER:     turnover_reg     <= i_reg_wdata[4:0];
        `ADDR_HOT_COEFF:    hot_coeff_reg    <= i_reg_wdata[6:0];
        `ADDR_COLD_COEFF:   cold_coeff_reg   <= i_reg_wdata[6:0];
        `ADDR_TRIM_INIT:    trim_init_reg    <= i_reg_wdata;
        `ADDR_TRIM_SCALE:   trim_scale_reg   <= i_reg_wdata;
        default: ; // Read-only and unmapped addresses ignore writes.
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Final trim readouts derived from the net correction value.
  // The digital readout stays at its zero-correction code and the analog readout
  // shows only bits 6:1 of the net correction; this keeps the readouts simple
  // at the cost of dropping bit 0 and every bit above bit 6 of the correction.
  always @(posedge i_clk) begin
    if (i_rst) begin
      final_analog_reg  <= `RST_ZERO;
      final_digital_reg <= `RST_ZERO;
    end else begin
      final_analog_reg  <= {2'b00, net_corr[6:1]};
      final_digital_reg <= `DIGITAL_TRIM_BIAS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply transition time stamps.
  // Supply edges are found against a registered copy that resets to mains, so
  // a device that leaves reset on mains shows no false switchover; a device
  // that leaves reset on battery takes that as its first switchover.
  always @(posedge i_clk) begin
    if (i_rst) begin
      on_batt_reg  <= 1'b0;
      mb_taken_reg <= 1'b0;
      for (k = 0; k < `STAMP_BYTES; k = k + 1) begin
        stamp_mb_reg[k] <= `RST_ZERO;
        stamp_bm_reg[k] <= `RST_ZERO;
      end
    end else begin
      on_batt_reg <= i_on_battery;
      if (wr_stamp_clear) begin
        mb_taken_reg <= 1'b0;
        for (k = 0; k < `STAMP_BYTES; k = k + 1) begin
          stamp_mb_reg[k] <= `RST_ZERO;
          stamp_bm_reg[k] <= `RST_ZERO;
        end
      end
      // A capture in the clearing cycle wins over the clear.
      if (to_batt && !mb_taken_reg) begin
        mb_taken_reg <= 1'b1;
        for (k = 0; k < `STAMP_BYTES; k = k + 1) begin
          stamp_mb_reg[k] <= now_bytes[k*8 +: 8];
        end
      end
      if (to_main) begin
        for (k = 0; k < `STAMP_BYTES; k = k + 1) begin
          stamp_bm_reg[k] <= now_bytes[k*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summer time adjustment, once per schedule arming.
  // The pulses last one cycle; the flag is the only lasting record, and a
  // disable clears it even in a cycle in which a schedule fires.
  always @(posedge i_clk) begin
    if (i_rst) begin
      applied_reg    <= 1'b0;
      fwd_armed_reg  <= 1'b0;
      rev_armed_reg  <= 1'b0;
      fwd_hit_reg    <= 1'b0;
      rev_hit_reg    <= 1'b0;
      o_hour_advance <= 1'b0;
      o_hour_retard  <= 1'b0;
    end else begin
      o_hour_advance <= 1'b0;
      o_hour_retard  <= 1'b0;
      // A schedule is armed only on an hour boundary when it did not match.
      if (i_hour_tick) begin
        fwd_armed_reg <= enable && !fwd_match;
        rev_armed_reg <= enable && !rev_match;
      end
      fwd_hit_reg <= fwd_match;
      rev_hit_reg <= rev_match;
      if (fwd_fire) begin
        o_hour_advance <= 1'b1;
        applied_reg    <= 1'b1;
      end else if (rev_fire) begin
        o_hour_retard <= 1'b1;
        applied_reg   <= 1'b0;
        rev_armed_reg <= 1'b0;
      end
      if (!enable || dst_off_wr) begin
        applied_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux.
  // Reads have no side effect, so software may poll the flag, the stamps and
  // the temperature code as often as it likes.
  always @* begin
    o_reg_rdata = `RST_ZERO;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `ADDR_FWD_MONTH:     o_reg_rdata = fwd_month_reg;
        `ADDR_FWD_DAY_WEEK:  o_reg_rdata = fwd_day_week_reg;
        `ADDR_FWD_DATE:      o_reg_rdata = fwd_date_reg;
        `ADDR_FWD_HOUR:      o_reg_rdata = fwd_hour_reg;
        `ADDR_REV_MONTH:     o_reg_rdata = rev_month_reg;
        `ADDR_REV_DAY_WEEK:  o_reg_rdata = rev_day_week_reg;
        `ADDR_REV_DATE:      o_reg_rdata = rev_date_reg;
        `ADDR_REV_HOUR:      o_reg_rdata = rev_hour_reg;
        `ADDR_STATUS:        o_reg_rdata = {2'b00, applied_reg, 5'h00};
        `ADDR_PWR_CTRL:      o_reg_rdata = {temp_sense_enable_reg, 7'h00};
        `ADDR_TEMP_LOW:      o_reg_rdata = temp_code[7:0];
        `ADDR_TEMP_HIGH:     o_reg_rdata = {6'h00, temp_code[9:8]};
        `ADDR_NET_CORR_LOW:  o_reg_rdata = net_corr[7:0];
        `ADDR_NET_CORR_HIGH: o_reg_rdata = net_corr[15:8];
        `ADDR_TURNOVER:      o_reg_rdata = {3'b000, turnover_reg};
        `ADDR_HOT_COEFF:     o_reg_rdata = {1'b0, hot_coeff_reg};
        `ADDR_COLD_COEFF:    o_reg_rdata = {1'b0, cold_coeff_reg};
        `ADDR_TRIM_INIT:     o_reg_rdata = trim_init_reg;
        `ADDR_TRIM_SCALE:    o_reg_rdata = trim_scale_reg;
        `ADDR_FINAL_ANALOG:  o_reg_rdata = final_analog_reg;
        `ADDR_FINAL_DIGITAL: o_reg_rdata = final_digital_reg;
        default: begin
          if (i_reg_addr >= `ADDR_STAMP_MB_BASE &&
              i_reg_addr < `ADDR_STAMP_MB_BASE + `STAMP_BYTES) begin
            o_reg_rdata = stamp_mb_reg[i_reg_addr[2:0]];
          end else if (i_reg_addr >= `ADDR_STAMP_BM_BASE &&
                       i_reg_addr < `ADDR_STAMP_BM_BASE + `STAMP_BYTES) begin
            o_reg_rdata = stamp_bm_reg[i_reg_addr[2:0]];
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtc_aux_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_aux_assertions (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_on_battery,
  input wire logic       o_hour_advance,
  input wire logic       o_hour_retard,
  input wire logic       o_summer_time_applied_flag
);
  //////////////////////////////////////////////////////////////////////////////
  // Every check samples on the one clock and rests while reset is high.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // A stamp clear and a stamp read, both with the supply steady for two cycles.
  sequence clear_write;
    i_reg_wr && i_reg_addr == 8'h09 && i_reg_wdata[7] && $stable(i_on_battery)
      && $past(i_on_battery, 2) == i_on_battery;
  endsequence
  sequence stamp_read;
    i_reg_rd && i_reg_addr[7:4] == 4'h3 && $stable(i_on_battery)
      && $past(i_on_battery, 2) == i_on_battery;
  endsequence
  sequence date_write;
    i_reg_wr && i_reg_addr == 8'h22;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // Register port checks.
  AST_STAMP_CLEAR: assert property (clear_write ##1 stamp_read |-> o_reg_rdata == 8'h00)
    else $error("stamp byte not zero after clear");
  AST_FWD_RST: assert property ($past(i_rst) && i_reg_rd && i_reg_addr == 8'h20 |-> o_reg_rdata == 8'h00)
    else $error("forward month not zero after reset");
  AST_REV_RST: assert property ($past(i_rst) && i_reg_rd && i_reg_addr == 8'h24 |-> o_reg_rdata == 8'h10)
    else $error("reverse month not ten after reset");
  AST_TEMP_HI: assert property (i_reg_rd && i_reg_addr == 8'h29 |-> o_reg_rdata[7:2] == 6'h00)
    else $error("upper temperature bits not zero");
  AST_DATE_WR: assert property (date_write ##1 (i_reg_rd && i_reg_addr == 8'h22) |-> o_reg_rdata == $past(i_reg_wdata))
    else $error("forward date does not read back");

  //////////////////////////////////////////////////////////////////////////////
  // Summer time checks.
  AST_DIS_CLR: assert property (i_reg_wr && i_reg_addr == 8'h20 && !i_reg_wdata[7] |=> !o_summer_time_applied_flag)
    else $error("applied flag survives disable");
  AST_FLAG_RISE: assert property ($rose(o_summer_time_applied_flag) |-> ##[0:1] (o_hour_advance || $past(o_hour_advance)))
    else $error("applied flag set without advance");
  AST_RET_CLR: assert property (o_hour_retard |-> ##[0:1] !o_summer_time_applied_flag)
    else $error("applied flag kept after retard");
  AST_ADV_PULSE: assert property (o_hour_advance |=> !o_hour_advance)
    else $error("advance longer than one cycle");
  AST_EXCL: assert property (!(o_hour_advance && o_hour_retard))
    else $error("advance and retard together");
endmodule
`default_nettype wire

// [rtc_aux_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_aux_tb;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tv = 1'b0;
  logic        lst = 1'b0, tick = 1'b0, bat = 1'b0, adv, ret, flag;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d, v, ofs;
  logic [7:0]  secs = 8'h00, mins = 8'h00, hrs = 8'h00, date = 8'h00, mon = 8'h00;
  logic [2:0]  wday = 3'h0, wkm = 3'h0;
  logic [9:0]  tsamp = 10'h000, code;
  logic [39:0] s1, s2, sx;
  logic [63:0] cfg = 64'h0301_7b10_0215_0083;
  logic [35:0] stp [0:3] = '{36'h0_3158_1010, 36'h0_3158_2015, 36'h1_0288_2349, 36'h1_0288_334a};
  logic [15:0] net;
  logic [4:0]  xt;
  logic [6:0]  hc, cc;
  integer      seed = 32'h957f_db91;
  integer      errors = 0, comparisons = 0, i, j, t1, t2;

  rtc_aux i_rtc_aux (
    .i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rtc_seconds(secs), .i_rtc_minutes(mins),
    .i_rtc_hours(hrs), .i_rtc_date(date), .i_rtc_month(mon), .i_rtc_weekday(wday),
    .i_rtc_week_of_month(wkm), .i_rtc_last_week(lst), .i_hour_tick(tick),
    .i_on_battery(bat), .i_temp_valid(tv), .i_temp_sample(tsamp), .o_hour_advance(adv),
    .o_hour_retard(ret), .o_summer_time_applied_flag(flag));

  // The clock runs at 40 MHz.
  always #12.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers that work out expected values.
  function integer rn(input integer n);
    rn = $unsigned($random(seed)) % n;
  endfunction
  function [7:0] bcd(input integer n);
    bcd = 8'(((n / 10) << 4) | (n % 10));
  endfunction
  function [15:0] exp_net(input [9:0] c, input [4:0] t, input [6:0] h, input [6:0] cd,
                          input [7:0] o);
    integer rf, dv, p;
    begin
      rf = t[4] ? 596 - t[3:0] : 596 + t[3:0];
      dv = c - rf;
      p = ((c >= rf) ? h : cd) * dv * dv;
      exp_net = 16'({{8{o[7]}}, o} + (p >> 12));
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus tasks; each leaves its strobe for the next task to change.
  task chk8(input logic [7:0] g, input logic [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task idle(input integer n);
    begin
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] x);
    begin
      rd <= 1'b0;
      wr <= 1'b1;
      addr <= a;
      wdata <= x;
      @(posedge clk);
    end
  endtask
  task rd_reg(input logic [7:0] a, output logic [7:0] x);
    begin
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(negedge clk);
      x = rdata;
      @(posedge clk);
    end
  endtask
  // Moves the clock bytes and the supply source together, then lets the capture land.
  task flip(input logic b, output logic [39:0] x);
    begin
      x = {bcd(1 + rn(12)), bcd(1 + rn(28)), bcd(rn(24)), bcd(rn(60)), bcd(rn(60))};
      {mon, date, hrs, mins, secs} <= x;
      bat <= b;
      idle(3);
    end
  endtask
  task stamp_chk(input logic [7:0] base, input logic [39:0] e);
    integer k;
    begin
      for (k = 0; k < 5; k = k + 1) begin
        rd_reg(8'(base + k), d);
        chk8(d, e[8 * k +: 8]);
      end
    end
  endtask
  // Applies one clock value with an hour tick and collects the pulses that follow.
  task dst_step(input logic [35:0] s);
    integer k;
    logic   a, r;
    begin
      {mon, date, hrs} <= s[35:12];
      wday <= s[10:8];
      wkm <= s[6:4];
      lst <= s[3];
      tick <= 1'b1;
      a = 1'b0;
      r = 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk);
        tick <= 1'b0;
        @(negedge clk);
        a = a | adv;
        r = r | ret;
      end
      chk8({7'h00, a}, {7'h00, s[2]});
      chk8({7'h00, r}, {7'h00, s[1]});
      chk8({7'h00, flag}, {7'h00, s[0]});
      @(posedge clk);
    end
  endtask
  task end_sim;
    begin
      if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, stamps, register traffic, schedules, temperature.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 8'h20; i < 8'h28; i = i + 1) begin
      rd_reg(8'(i), d);
      chk8(d, (i == 8'h24) ? 8'h10 : 8'h00);
    end
    rd_reg(8'h40, d);
    chk8(d, 8'h00);
    stamp_chk(8'h30, 40'h0);
    flip(1'b1, s1);
    flip(1'b0, s2);
    stamp_chk(8'h30, s1);
    stamp_chk(8'h38, s2);
    flip(1'b1, sx);
    flip(1'b0, s2);
    stamp_chk(8'h30, s1);
    stamp_chk(8'h38, s2);
    wr_reg(8'h09, 8'h80);
    stamp_chk(8'h30, 40'h0);
    stamp_chk(8'h38, 40'h0);
    flip(1'b1, s1);
    stamp_chk(8'h30, s1);
    // Random legal values in every schedule register read straight back.
    for (j = 0; j < 32; j = j + 1) begin
      i = j % 8;
      case (i % 4)
        0: v = bcd(1 + rn(12)) | {(i == 0) && (rn(2) == 1), 7'h00};
        1: v = {1'b0, 1'(rn(2)), 3'(1 + rn(5)), 3'(rn(7))};
        2: v = bcd(1 + rn(31));
        default: v = bcd(rn(24));
      endcase
      wr_reg(8'(8'h20 + i), v);
      rd_reg(8'(8'h20 + i), d);
      chk8(d, v);
    end
    // Date-based forward and last-week reverse schedules, armed an hour ahead.
    for (i = 0; i < 8; i = i + 1) wr_reg(8'(8'h20 + i), cfg[8 * i +: 8]);
    idle(1);
    for (i = 0; i < 6; i = i + 1) dst_step(stp[i % 4]);
    rd_reg(8'h07, d);
    chk8(d & 8'h20, 8'h20);
    wr_reg(8'h20, 8'h03);
    rd_reg(8'h07, d);
    chk8(d & 8'h20, 8'h00);
    chk8({7'h00, flag}, 8'h00);
    // Averaged temperature code and compensation on both sides of the turnover point.
    xt = 5'(rn(32));
    hc = 7'(rn(128));
    cc = 7'(rn(128));
    ofs = 8'(rn(256));
    wr_reg(8'h2c, {3'h0, xt});
    wr_reg(8'h2d, {1'b0, hc});
    wr_reg(8'h2e, {1'b0, cc});
    wr_reg(8'h0b, ofs);
    wr_reg(8'h09, 8'h80);
    idle(1);
    for (j = 0; j < 2; j = j + 1) begin
      t1 = (j == 0) ? 450 + rn(100) : 640 + rn(80);
      t2 = t1 + 2 * rn(3);
      code = 10'((t1 + t2) / 2);
      net = exp_net(code, xt, hc, cc, ofs);
      tv <= 1'b1;
      tsamp <= 10'(t1);
      @(posedge clk);
      tsamp <= 10'(t2);
      @(posedge clk);
      tv <= 1'b0;
      idle(3);
      rd_reg(8'h28, d);
      chk8(d, code[7:0]);
      rd_reg(8'h29, d);
      chk8(d, {6'h00, code[9:8]});
      rd_reg(8'h2a, d);
      chk8(d, net[7:0]);
      rd_reg(8'h2b, d);
      chk8(d, net[15:8]);
      rd_reg(8'h0e, d);
      chk8(d, {2'b00, net[6:1]});
      rd_reg(8'h0f, d);
      chk8(d, 8'h10);
      wr_reg(8'h28, ~code[7:0]);
      rd_reg(8'h28, d);
      chk8(d, code[7:0]);
    end
    // A second reset in mid-run restores the schedule defaults.
    wr_reg(8'h24, 8'h05);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd_reg(8'h24, d);
    chk8(d, 8'h10);
    rd_reg(8'h20, d);
    chk8(d, 8'h00);
    end_sim;
  end

  // Cuts a hang short long after the sequence should have ended.
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    end_sim;
  end
endmodule

bind rtc_aux rtc_aux_assertions i_rtc_aux_assertions (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_on_battery(i_on_battery), .o_hour_advance(o_hour_advance),
  .o_hour_retard(o_hour_retard), .o_summer_time_applied_flag(o_summer_time_applied_flag));
`default_nettype wire
